/* File: dv/pspv_sensor_model.sv */
`timescale 1ns/10ps
module pspv_sensor_model (
  input wire logic clk_i, // Clock
  input wire logic [15:0] level_i, // Pressure to report
  output logic [15:0] feedback_o // To controller
);
  // Registered, so a step lands one clock after it is asked for
  always_ff @(posedge clk_i)
    feedback_o <= level_i;
endmodule // pspv_sensor_model

/* File: dv/pspv_top_props.sv */
`timescale 1ns/10ps
module pspv_top_props #(
  parameter int unsigned TICK_CYCLES = 10
)(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic [15:0] freq_o, // Frequency
  input wire logic asleep_o, // Asleep
  input wire logic burst_pressure_fault_o, // Fault
  input wire logic irq_o // Interrupt
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acked");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  req_drop_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack after release");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  dat_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits set");
  sleep_zero_a: assert property (asleep_o |-> freq_o == 16'h0000)
    else $error("speed while asleep");
  reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o && !asleep_o
    && !burst_pressure_fault_o && !irq_o && freq_o == 16'h0000)
    else $error("outputs not cleared");
endmodule // pspv_top_props

bind pspv_top pspv_top_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .freq_o(freq_o),
  .asleep_o(asleep_o), .burst_pressure_fault_o(burst_pressure_fault_o), .irq_o(irq_o));

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`include "pspv_consts.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [15:0] level = 16'h0000;
  logic [31:0] rdat;
  logic [15:0] fb;
  logic [15:0] freq;
  logic ack;
  logic sleep;
  logic fault;
  logic irq;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;

  initial forever #2.5 clk_i = ~clk_i;

  pspv_sensor_model u_sensor (.clk_i(clk_i), .level_i(level), .feedback_o(fb));
  // Short tick keeps delays of whole ticks cheap to run
  pspv_top #(.TICK_CYCLES(10)) DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .feedback_i(fb), .freq_o(freq), .asleep_o(sleep), .burst_pressure_fault_o(fault), .irq_o(irq));

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, idx, {16'h0000, d}, q);
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0000_0000, q);
    check(q, exp);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim)
    begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic t_reset;
    rd(`PSPV_CFG_GAIN, 32'h0000_00C8);
    rd(`PSPV_CFG_INTEG_TIME, 32'h0000_000A);
    rd(`PSPV_CFG_DERIV_TIME, 32'h0000_0000);
    rd(`PSPV_CFG_SLEEP_THR, 32'h0000_03E8);
    rd(`PSPV_CFG_WAKE_THR, 32'h0000_0384);
    rd(`PSPV_CFG_WAKE_DLY, 32'h0000_000A);
    rd(`PSPV_CFG_DIST_BAND, 32'h0000_0005);
    rd(`PSPV_CFG_HIGH_THR, 32'h0000_05DC);
    rd(`PSPV_CFG_LOW_THR, 32'h0000_01F4);
    rd(`PSPV_CFG_SENSOR_RANGE, 32'h0000_03E8);
    wr(`PSPV_IDX_STATUS, 16'h0007);
    rd(`PSPV_IDX_STATUS, 32'h0000_0000);
    rd(6'h3F, 32'h0000_0000);
    $display("test reset done");
  endtask

  task automatic t_preset;
    // Feedback on setpoint keeps the burst fault out of the status word
    level <= 16'h01F4;
    wr(`PSPV_CFG_SETPOINT, 16'h01F4);
    wr(`PSPV_CFG_PRESET_FREQ, 16'h04D2);
    wr(`PSPV_CFG_PRESET_HOLD, 16'h0003);
    wr(`PSPV_CFG_CTRL, 16'h0001);
    check(freq, 32'h0000_04D2);
    rd(`PSPV_IDX_STATUS, 32'h0000_0001);
    settle(40);
    rd(`PSPV_IDX_STATUS, 32'h0000_0002);
    check(freq, 32'h0000_04D2);
    wr(`PSPV_CFG_CTRL, 16'h0000);
    check(freq, 32'h0000_0000);
    $display("test preset done");
  endtask

  task automatic t_loop;
    level <= 16'h0258;
    wr(`PSPV_CFG_SETPOINT, 16'h01F4);
    wr(`PSPV_CFG_FREQ_LOW, 16'h03E8);
    wr(`PSPV_CFG_FREQ_HIGH, 16'h07D0);
    wr(`PSPV_CFG_PRESET_FREQ, 16'h05DC);
    wr(`PSPV_CFG_PRESET_HOLD, 16'h0000);
    wr(`PSPV_CFG_CTRL, 16'h0003);
    settle(60);
    check(freq, 32'h0000_03E8);
    wr(`PSPV_CFG_CTRL, 16'h0005);
    settle(60);
    check(freq, 32'h0000_07D0);
    wr(`PSPV_CFG_DEADBAND, 16'h00C8);
    wr(`PSPV_CFG_CTRL, 16'h0003);
    settle(60);
    check(freq, 32'h0000_07D0);
    wr(`PSPV_CFG_DEADBAND, 16'h0000);
    $display("test loop done");
  endtask

  task automatic t_sleep;
    wr(`PSPV_CFG_SLEEP_DLY, 16'h0005);
    wr(`PSPV_CFG_WAKE_DLY, 16'h0003);
    wr(`PSPV_IDX_INT_ENABLE, 16'h0002);
    wr(`PSPV_CFG_CTRL, 16'h000B);
    wait_on(sleep, 1'b1, 200);
    check(freq, 32'h0000_0000);
    check(irq, 1'b1);
    rd(`PSPV_IDX_INT_STATUS, 32'h0000_0002);
    wr(`PSPV_IDX_INT_ENABLE, 16'h0000);
    check(irq, 1'b0);
    wr(`PSPV_IDX_INT_CLEAR, 16'h0002);
    rd(`PSPV_IDX_INT_STATUS, 32'h0000_0000);
    // Short dip below wake level must not count toward the wake delay
    level <= 16'h0190;
    settle(15);
    level <= 16'h0258;
    settle(15);
    level <= 16'h0190;
    wait_on(sleep, 1'b0, 80);
    check(n >= 20, 1'b1);
    check(freq, 32'h0000_03E8);
    $display("test sleep done");
  endtask

  task automatic t_fault;
    wr(`PSPV_CFG_CTRL, 16'h0003);
    wr(`PSPV_CFG_BURST_DLY, 16'h0004);
    wr(`PSPV_IDX_INT_ENABLE, 16'h0001);
    level <= 16'h0320;
    wait_on(fault, 1'b1, 80);
    check(n >= 25, 1'b1);
    check(irq, 1'b1);
    level <= 16'h0258;
    wait_on(fault, 1'b0, 12);
    check(fault, 1'b0);
    level <= 16'h00C8;
    wait_on(fault, 1'b1, 80);
    check(fault, 1'b1);
    level <= 16'h00FA;
    wait_on(fault, 1'b0, 12);
    check(fault, 1'b0);
    wr(`PSPV_CFG_SENSOR_RANGE, 16'h07D0);
    rd(`PSPV_IDX_PRESSURE, 32'h0000_01F4);
    $display("test fault done");
  endtask

  task automatic t_dist;
    wr(`PSPV_CFG_SLEEP_DLY, 16'h0002);
    level <= 16'h01FE;
    wr(`PSPV_CFG_CTRL, 16'h0013);
    settle(60);
    check(sleep, 1'b0);
    level <= 16'h01F5;
    wait_on(sleep, 1'b1, 60);
    check(sleep, 1'b1);
    level <= 16'h0190;
    wait_on(sleep, 1'b0, 12);
    check(n <= 9, 1'b1);
    $display("test dist done");
  endtask

  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_preset();
    t_loop();
    t_sleep();
    t_fault();
    t_dist();
    give_verdict();
  end

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      give_verdict();
    end
  end
endmodule // tb_top

/* File: hw/pspv_consts.svh */
`ifndef PSPV_CONSTS_SVH
`define PSPV_CONSTS_SVH

// Timing: clock period and the 0.1 s base tick
`define PSPV_CLK_PERIOD_NS 32'h0000_0005
`define PSPV_TICK_PERIOD_NS 32'h05F5_E100
`define PSPV_TICK_CYCLES (`PSPV_TICK_PERIOD_NS / `PSPV_CLK_PERIOD_NS)
`define PSPV_TICK_W 25

// Configuration word indices; byte address is index times four
`define PSPV_NCFG 20
`define PSPV_CFG_CTRL 5'h00
`define PSPV_CFG_SETPOINT 5'h01
`define PSPV_CFG_GAIN 5'h02
`define PSPV_CFG_INTEG_TIME 5'h03
`define PSPV_CFG_DERIV_TIME 5'h04
`define PSPV_CFG_SAMPLE_PERIOD 5'h05
`define PSPV_CFG_DEADBAND 5'h06
`define PSPV_CFG_PRESET_FREQ 5'h07
`define PSPV_CFG_PRESET_HOLD 5'h08
`define PSPV_CFG_SLEEP_THR 5'h09
`define PSPV_CFG_WAKE_THR 5'h0A
`define PSPV_CFG_SLEEP_DLY 5'h0B
`define PSPV_CFG_WAKE_DLY 5'h0C
`define PSPV_CFG_DIST_BAND 5'h0D
`define PSPV_CFG_BURST_DLY 5'h0E
`define PSPV_CFG_HIGH_THR 5'h0F
`define PSPV_CFG_LOW_THR 5'h10
`define PSPV_CFG_SENSOR_RANGE 5'h11
`define PSPV_CFG_FREQ_LOW 5'h12
`define PSPV_CFG_FREQ_HIGH 5'h13

// Read-only and interrupt word indices
`define PSPV_IDX_STATUS 6'h14
`define PSPV_IDX_FREQ 6'h15
`define PSPV_IDX_PRESSURE 6'h16
`define PSPV_IDX_INT_STATUS 6'h17
`define PSPV_IDX_INT_CLEAR 6'h18
`define PSPV_IDX_INT_ENABLE 6'h19

// Reset values, units: 0.01 gain, 0.1 s, 0.1 %, 0.01 Hz, 0.01 MPa
`define PSPV_RST_CTRL 16'h0000
`define PSPV_RST_GAIN 16'h00C8
`define PSPV_RST_INTEG_TIME 16'h000A
`define PSPV_RST_SLEEP_THR 16'h03E8
`define PSPV_RST_WAKE_THR 16'h0384
`define PSPV_RST_SLEEP_DLY 16'h03E8
`define PSPV_RST_WAKE_DLY 16'h000A
`define PSPV_RST_DIST_BAND 16'h0005
`define PSPV_RST_HIGH_THR 16'h05DC
`define PSPV_RST_LOW_THR 16'h01F4
`define PSPV_RST_SENSOR_RANGE 16'h03E8
`define PSPV_RST_FREQ_HIGH 16'h1388

// Control field layout and codes
`define PSPV_CTRL_RUN 0
`define PSPV_POL_POS 2'h1
`define PSPV_POL_NEG 2'h2
`define PSPV_SMODE_NORMAL 2'h1
`define PSPV_SMODE_DIST 2'h2
`define PSPV_PCT_FULL 16'h03E8

// Delay timer slots
`define PSPV_TMR_PRE 0
`define PSPV_TMR_SLP 1
`define PSPV_TMR_WAK 2
`define PSPV_TMR_BST 3

`endif

/* File: hw/pspv_delay.sv */
`timescale 1ns/10ps
module pspv_delay
  import pspv_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic tick_i, // 0.1 s enable
  pspv_dly_if.timer dly // Run, limit in 0.1 s, done
);
  pspv_dly_st_t q;
  pspv_dly_st_t nx;

  always_comb
  begin
    nx = q;
    if (!dly.run)
    begin
      nx = '0;
    end
    else if (q.cnt >= dly.limit)
    begin
      nx.done = 1'b1;
    end
    else if (tick_i)
    begin
      nx.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= nx;
    end
  end

  assign dly.done = q.done;
endmodule // pspv_delay

/* File: hw/pspv_dly_if.sv */
`timescale 1ns/10ps
interface pspv_dly_if;
  logic run;
  logic [15:0] limit;
  logic done;
  modport owner (output run, output limit, input done);
  modport timer (input run, input limit, output done);
endinterface

/* File: hw/pspv_pkg.sv */
`include "pspv_consts.svh"
package pspv_pkg;

  typedef enum logic [1:0] {
    PSPV_IDLE = 2'b00,
    PSPV_PRESET = 2'b01,
    PSPV_REGULATE = 2'b10,
    PSPV_SLEEP = 2'b11
  } pspv_state_t;

  typedef logic [`PSPV_NCFG-1:0][15:0] pspv_cfg_t;

  typedef struct packed {
    pspv_state_t state;
    pspv_cfg_t cfg;
    logic [15:0] freq;
    logic signed [16:0] e1;
    logic signed [16:0] e2;
    logic [15:0] samp;
    logic [15:0] fb_s1;
    logic [15:0] fb_s2;
    logic [15:0] fb_s3;
    logic [15:0] fb;
    logic fault;
    logic [2:0] int_stat;
    logic [2:0] int_en;
    logic ack;
    logic [31:0] dat;
  } pspv_top_st_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic done;
  } pspv_dly_st_t;

  typedef struct packed {
    logic [`PSPV_TICK_W-1:0] cnt;
    logic tick;
  } pspv_tick_st_t;

endpackage

/* File: hw/pspv_tick.sv */
`timescale 1ns/10ps
`include "pspv_consts.svh"
module pspv_tick
  import pspv_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSPV_TICK_CYCLES
)(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  output logic tick_o // One-cycle pulse every 0.1 s
);
  pspv_tick_st_t q;
  pspv_tick_st_t nx;

  always_comb
  begin
    nx = q;
    nx.tick = 1'b0;
    if (q.cnt >= `PSPV_TICK_W'(TICK_CYCLES - 1))
    begin
      nx.cnt = '0;
      nx.tick = 1'b1;
    end
    else
    begin
      nx.cnt = q.cnt + `PSPV_TICK_W'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
    end
    else
    begin
      q <= nx;
    end
  end

  assign tick_o = q.tick;
endmodule // pspv_tick

/* File: hw/pspv_top.sv */
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/10ps
`include "pspv_consts.svh"
// Overview of operation
// - Correction uses proportional gain and integration time
// - Derivative term active only when time nonzero
// - Loop updates once per sampling period
// - Deviation inside dead band holds output
// - Preset frequency held before regulation starts
// - High feedback at lower limit enters sleep
// - Low feedback while asleep wakes after delay
// - Sleep and wake delays set independently
// - Disturbance sleep uses deviation band entry
// - High pressure raises self-clearing burst fault
// - Low pressure raises self-clearing burst fault
// - Burst detection delay precedes either fault
// - Sensor range scales reported feedback pressure
// - Polarity sets direction of frequency correction
// - Disturbance sleep wakes at once, positive polarity
module pspv_top
  import pspv_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `PSPV_TICK_CYCLES
)(
  input wire logic clk_i, // System clock, 200 MHz
  input wire logic rst_i, // Synchronous reset, high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [15:0] feedback_i, // Sensor feedback, 0.1 % of range
  output logic [15:0] freq_o, // Frequency command, 0.01 Hz
  output logic asleep_o, // Drive parked at zero speed
  output logic burst_pressure_fault_o, // Pressure fault level
  output logic irq_o // Interrupt, high level
);
  pspv_top_st_t q;
  pspv_top_st_t nx;
  logic tick;
  logic [3:0] tmr_run;
  logic [3:0][15:0] tmr_lim;
  logic [3:0] tmr_done;

  logic [15:0] sp;
  logic [15:0] dev;
  logic [31:0] fbk;
  logic [1:0] pol;
  logic [1:0] smode;
  logic run;
  logic signed [16:0] e;
  logic signed [17:0] de;
  logic signed [18:0] dde;
  logic signed [47:0] kp;
  logic signed [47:0] ts;
  logic signed [47:0] tis;
  logic signed [47:0] acc;
  logic signed [47:0] nf;
  logic [15:0] tsafe;
  logic [15:0] pid_freq;
  logic [15:0] preset;
  logic in_db;
  logic hi_c;
  logic lo_c;
  logic slp_c;
  logic wk_c;
  logic [5:0] idx;
  logic acc_en;
  logic [2:0] ev;
  logic [2:0] clr;

  function automatic logic [31:0] pspv_mul(input logic [15:0] a, input logic [15:0] b);
    return 32'(a) * 32'(b);
  endfunction

  function automatic logic signed [47:0] pspv_s48(input logic [15:0] a);
    return $signed({32'h0000_0000, a});
  endfunction

  function automatic pspv_cfg_t pspv_cfg_reset();
    pspv_cfg_t c;
    c = '0;
    c[`PSPV_CFG_CTRL] = `PSPV_RST_CTRL;
    c[`PSPV_CFG_GAIN] = `PSPV_RST_GAIN;
    c[`PSPV_CFG_INTEG_TIME] = `PSPV_RST_INTEG_TIME;
    c[`PSPV_CFG_SLEEP_THR] = `PSPV_RST_SLEEP_THR;
    c[`PSPV_CFG_WAKE_THR] = `PSPV_RST_WAKE_THR;
    c[`PSPV_CFG_SLEEP_DLY] = `PSPV_RST_SLEEP_DLY;
    c[`PSPV_CFG_WAKE_DLY] = `PSPV_RST_WAKE_DLY;
    c[`PSPV_CFG_DIST_BAND] = `PSPV_RST_DIST_BAND;
    c[`PSPV_CFG_HIGH_THR] = `PSPV_RST_HIGH_THR;
    c[`PSPV_CFG_LOW_THR] = `PSPV_RST_LOW_THR;
    c[`PSPV_CFG_SENSOR_RANGE] = `PSPV_RST_SENSOR_RANGE;
    c[`PSPV_CFG_FREQ_HIGH] = `PSPV_RST_FREQ_HIGH;
    return c;
  endfunction

  pspv_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  for (genvar i = 0; i < 4; i++)
  begin : g_tmr
    pspv_dly_if u_if();
    assign u_if.run = tmr_run[i];
    assign u_if.limit = tmr_lim[i];
    assign tmr_done[i] = u_if.done;
    pspv_delay u_dly (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .dly(u_if)
    );
  end

  always_comb
  begin
    sp = q.cfg[`PSPV_CFG_SETPOINT];
    run = q.cfg[`PSPV_CFG_CTRL][`PSPV_CTRL_RUN];
    pol = q.cfg[`PSPV_CFG_CTRL][2:1];
    smode = q.cfg[`PSPV_CFG_CTRL][4:3];
    fbk = pspv_mul(q.fb, `PSPV_PCT_FULL);
    dev = (q.fb >= sp) ? q.fb - sp : sp - q.fb;
    // Thresholds compared as fb*1000 against sp*pct, no division
    in_db = pspv_mul(dev, `PSPV_PCT_FULL) <= pspv_mul(sp, q.cfg[`PSPV_CFG_DEADBAND]);
    hi_c = fbk >= pspv_mul(sp, q.cfg[`PSPV_CFG_HIGH_THR]);
    lo_c = fbk < pspv_mul(sp, q.cfg[`PSPV_CFG_LOW_THR]);
    wk_c = fbk < pspv_mul(sp, q.cfg[`PSPV_CFG_WAKE_THR]);
    if (smode == `PSPV_SMODE_DIST)
    begin
      slp_c = pspv_mul(dev, `PSPV_PCT_FULL) <= pspv_mul(sp, q.cfg[`PSPV_CFG_DIST_BAND]);
    end
    else
    begin
      slp_c = (fbk > pspv_mul(sp, q.cfg[`PSPV_CFG_SLEEP_THR]))
        && (q.freq == q.cfg[`PSPV_CFG_FREQ_LOW]);
    end

    // Negative polarity flips the error sign
    if (pol == `PSPV_POL_NEG)
    begin
      e = $signed({1'b0, q.fb}) - $signed({1'b0, sp});
    end
    else
    begin
      e = $signed({1'b0, sp}) - $signed({1'b0, q.fb});
    end
    de = 18'(e) - 18'(q.e1);
    dde = 19'(e) - 19'(q.e1) - 19'(q.e1) + 19'(q.e2);
    // Zero period or integration time counts as the smallest step
    tsafe = (q.cfg[`PSPV_CFG_SAMPLE_PERIOD] == 16'h0000) ? 16'h0001 : q.cfg[`PSPV_CFG_SAMPLE_PERIOD];
    kp = pspv_s48(q.cfg[`PSPV_CFG_GAIN]);
    ts = pspv_s48(tsafe);
    tis = pspv_s48((q.cfg[`PSPV_CFG_INTEG_TIME] == 16'h0000) ? 16'h0001 : q.cfg[`PSPV_CFG_INTEG_TIME]);
    acc = kp * 48'(de) + (kp * 48'(e) * ts) / tis;
    if (q.cfg[`PSPV_CFG_DERIV_TIME] != 16'h0000)
    begin
      acc = acc + (kp * 48'(dde) * pspv_s48(q.cfg[`PSPV_CFG_DERIV_TIME])) / ts;
    end
    // Gain in 0.01 steps and error in 0.1 % steps land in 0.01 Hz after /10
    acc = acc / 48'sh0000_0000_000A;
    nf = pspv_s48(q.freq) + acc;
    if (nf > pspv_s48(q.cfg[`PSPV_CFG_FREQ_HIGH]))
    begin
      pid_freq = q.cfg[`PSPV_CFG_FREQ_HIGH];
    end
    else if (nf < pspv_s48(q.cfg[`PSPV_CFG_FREQ_LOW]))
    begin
      pid_freq = q.cfg[`PSPV_CFG_FREQ_LOW];
    end
    else
    begin
      pid_freq = nf[15:0];
    end
    preset = (q.cfg[`PSPV_CFG_PRESET_FREQ] > q.cfg[`PSPV_CFG_FREQ_HIGH]) ?
      q.cfg[`PSPV_CFG_FREQ_HIGH] : q.cfg[`PSPV_CFG_PRESET_FREQ];

    tmr_run[`PSPV_TMR_PRE] = q.state == PSPV_PRESET;
    tmr_lim[`PSPV_TMR_PRE] = q.cfg[`PSPV_CFG_PRESET_HOLD];
    tmr_run[`PSPV_TMR_SLP] = (q.state == PSPV_REGULATE) && (smode != 2'h0) && slp_c;
    tmr_lim[`PSPV_TMR_SLP] = q.cfg[`PSPV_CFG_SLEEP_DLY];
    tmr_run[`PSPV_TMR_WAK] = (q.state == PSPV_SLEEP) && wk_c;
    tmr_lim[`PSPV_TMR_WAK] = q.cfg[`PSPV_CFG_WAKE_DLY];
    tmr_run[`PSPV_TMR_BST] = run && (hi_c || lo_c);
    tmr_lim[`PSPV_TMR_BST] = q.cfg[`PSPV_CFG_BURST_DLY];
  end

  always_comb
  begin
    nx = q;
    ev = 3'h0;
    clr = 3'h0;
    idx = wb_adr_i[7:2];
    acc_en = wb_cyc_i && wb_stb_i && !q.ack;

    // Three-stage sampler; a new reading counts once stages 2 and 3 agree
    nx.fb_s1 = feedback_i;
    nx.fb_s2 = q.fb_s1;
    nx.fb_s3 = q.fb_s2;
    if (q.fb_s2 == q.fb_s3)
    begin
      nx.fb = q.fb_s3;
    end

    nx.fault = tmr_done[`PSPV_TMR_BST];
    ev[0] = tmr_done[`PSPV_TMR_BST] && !q.fault;

    case (q.state)
      PSPV_IDLE:
      begin
        nx.freq = 16'h0000;
        if (run)
        begin
          nx.state = PSPV_PRESET;
          nx.freq = preset;
        end
      end
      PSPV_PRESET:
      begin
        nx.freq = preset;
        if (tmr_done[`PSPV_TMR_PRE])
        begin
          nx.state = PSPV_REGULATE;
          nx.samp = 16'h0000;
        end
      end
      PSPV_REGULATE:
      begin
        if (tmr_done[`PSPV_TMR_SLP])
        begin
          nx.state = PSPV_SLEEP;
          nx.freq = 16'h0000;
          ev[1] = 1'b1;
        end
        else if (tick)
        begin
          if (q.samp + 16'h0001 >= tsafe)
          begin
            nx.samp = 16'h0000;
            nx.e1 = e;
            nx.e2 = q.e1;
            // Invalid polarity leaves the loop frozen at its last output
            if (!in_db && (pol == `PSPV_POL_POS || pol == `PSPV_POL_NEG))
            begin
              nx.freq = pid_freq;
            end
          end
          else
          begin
            nx.samp = q.samp + 16'h0001;
          end
        end
      end
      PSPV_SLEEP:
      begin
        nx.freq = 16'h0000;
        if ((smode == `PSPV_SMODE_DIST && pol == `PSPV_POL_POS && wk_c)
          || tmr_done[`PSPV_TMR_WAK])
        begin
          nx.state = PSPV_REGULATE;
          nx.freq = q.cfg[`PSPV_CFG_FREQ_LOW];
          nx.samp = 16'h0000;
          ev[2] = 1'b1;
        end
      end
      default:
      begin
        nx.state = PSPV_IDLE;
      end
    endcase

    if (!run)
    begin
      nx.state = PSPV_IDLE;
      nx.freq = 16'h0000;
      nx.e1 = '0;
      nx.e2 = '0;
      nx.samp = 16'h0000;
    end

    // Classic Wishbone: ack one cycle after the request, dropped the next
    nx.ack = acc_en;
    nx.dat = 32'h0000_0000;
    if (acc_en && wb_we_i)
    begin
      if (idx < 6'(`PSPV_NCFG))
      begin
        if (wb_sel_i[0])
        begin
          nx.cfg[idx[4:0]][7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          nx.cfg[idx[4:0]][15:8] = wb_dat_i[15:8];
        end
      end
      else if (idx == `PSPV_IDX_INT_CLEAR && wb_sel_i[0])
      begin
        clr = wb_dat_i[2:0];
      end
      else if (idx == `PSPV_IDX_INT_ENABLE && wb_sel_i[0])
      begin
        nx.int_en = wb_dat_i[2:0];
      end
    end
    else if (acc_en)
    begin
      if (idx < 6'(`PSPV_NCFG))
      begin
        nx.dat = {16'h0000, q.cfg[idx[4:0]]};
      end
      else if (idx == `PSPV_IDX_STATUS)
      begin
        nx.dat = {29'h0000_0000, q.fault, q.state};
      end
      else if (idx == `PSPV_IDX_FREQ)
      begin
        nx.dat = {16'h0000, q.freq};
      end
      else if (idx == `PSPV_IDX_PRESSURE)
      begin
        nx.dat = pspv_mul(q.fb, q.cfg[`PSPV_CFG_SENSOR_RANGE]) / 32'h0000_03E8;
      end
      else if (idx == `PSPV_IDX_INT_STATUS)
      begin
        nx.dat = {29'h0000_0000, q.int_stat};
      end
      else if (idx == `PSPV_IDX_INT_ENABLE)
      begin
        nx.dat = {29'h0000_0000, q.int_en};
      end
    end
    // A new event beats a clear in the same cycle
    nx.int_stat = (q.int_stat & ~clr) | ev;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.cfg <= pspv_cfg_reset();
    end
    else
    begin
      q <= nx;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign freq_o = q.freq;
  assign asleep_o = q.state == PSPV_SLEEP;
  assign burst_pressure_fault_o = q.fault;
  assign irq_o = |(q.int_stat & q.int_en);
endmodule // pspv_top
